// >>> shared/wake_rx_pkg.sv
// constants shared by the wake-up receiver control block and its timer.
// assumes a 125 MHz system clock and an AXI4-Lite master on 32-bit data.
package wake_rx_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  // sampling-on window, short setting
  localparam int SAMPLE_ON_TIME_NS = 200_000;
  // window length in system clocks, rounded down, at least one
  localparam int SAMPLE_ON_CYC = (SAMPLE_ON_TIME_NS / CLK_PERIOD_NS) < 1 ?
                                 1 : (SAMPLE_ON_TIME_NS / CLK_PERIOD_NS);
  localparam int OFF_CNT_W = 17;
  localparam logic [3:0] SEL_PARKED = 4'hF;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL_STAT_ZERO = 8'h00;
  localparam logic [7:0] ADDR_CTL_STAT_ONE = 8'h04;
  localparam logic [7:0] ADDR_RECEIVED_BYTE = 8'h08;
  localparam logic [7:0] ADDR_TIMING_CTL = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // control/status zero fields
  // ----------------------------------------------------------------
  localparam int CS0_DET_OUT = 7;
  localparam int CS0_IRQ_EN = 6;
  localparam int CS0_LOCKOUT = 5;
  localparam int CS0_DOUBLE = 4;
  localparam int CS0_DET_EN = 3;
  localparam int CS0_SHORT_CODE = 2;
  localparam int CS0_SENS = 1;
  localparam int CS0_READBACK = 0;

  // ----------------------------------------------------------------
  // control/status one fields
  // ----------------------------------------------------------------
  localparam int CS1_DATA_READY = 7;
  localparam int CS1_FILTER = 6;
  localparam int CS1_CARRIER = 5;
  localparam int CS1_ACK_DATA = 6;
  localparam int CS1_ACK_CARRIER = 4;
  localparam int CS1_CODE_B = 3;
  localparam int CS1_CODE_A = 2;
  localparam int CS1_VIOL = 1;
  localparam int CS1_IGNORE = 0;

  // timing control: bits 3:0 select, bits 5:4 mode
  localparam int TC_SEL_LSB = 0;
  localparam int TC_MODE_LSB = 4;

  // interrupt status bits
  localparam int IRQ_DATA = 0;
  localparam int IRQ_CARRIER = 1;
  localparam int IRQ_CODE_A = 2;
  localparam int IRQ_CODE_B = 3;
  localparam int IRQ_CODE_ERR = 4;
  localparam int IRQ_W = 5;

  // ----------------------------------------------------------------
  // reset values and responses
  // ----------------------------------------------------------------
  localparam logic [7:0] CS0_RESET = 8'h00;
  localparam logic [7:0] CS1_RESET = 8'h00;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// >>> src/off_interval_timer.sv
// sampling cycle sequencer: off interval counted on slow oscillator
// edges, then a sampling-on window counted on system clocks.
// assumes slow_rise_in is a one-cycle pulse already synchronised.
`timescale 1ns/100ps
module off_interval_timer #(
  parameter int ON_CYC = wake_rx_pkg::SAMPLE_ON_CYC
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic [3:0] sel_in, // off interval select
  input wire logic dbl_in, // off interval doubling
  input wire logic slow_rise_in, // slow oscillator rising edge pulse
  input wire logic code_err_in, // code error pulse, starts lockout
  output logic window_out, // sampling window active
  output logic lockout_out // lockout in progress
);

  typedef enum {ST_PARK, ST_OFF, ST_ON} seq_e;
  localparam int OW = wake_rx_pkg::OFF_CNT_W;
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  seq_e state_r;
  logic [OW-1:0] off_cnt_r;
  logic [OW-1:0] target_r;
  logic [31:0] on_cnt_r;
  logic [OW-1:0] target_nxt;
  logic off_end;

  assign target_nxt = (OW'(1) << (5'(sel_in) + 5'(dbl_in))) + OW'(1);
  assign off_end = (state_r == ST_OFF) && slow_rise_in &&
                   (off_cnt_r + OW'(1) == target_r);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_OFF;
      off_cnt_r <= '0;
      target_r <= OW'(2);
      on_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_PARK: begin
          if (sel_in != wake_rx_pkg::SEL_PARKED) begin
            state_r <= ST_OFF;
            off_cnt_r <= '0;
            target_r <= target_nxt;
          end
        end
        ST_OFF: begin
          // a lockout that ends while parked must not open a window
          if (sel_in == wake_rx_pkg::SEL_PARKED &&
              (!lockout_out || off_end)) begin
            state_r <= ST_PARK;
          end else if (off_end) begin
            state_r <= ST_ON;
            on_cnt_r <= '0;
          end else if (slow_rise_in) begin
            off_cnt_r <= off_cnt_r + OW'(1);
          end
        end
        ST_ON: begin
          if (code_err_in || on_cnt_r == 32'(ON_CYC - 1)) begin
            state_r <= ST_OFF;
            off_cnt_r <= '0;
            target_r <= target_nxt;
          end else begin
            on_cnt_r <= on_cnt_r + 32'd1;
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // lockout
  // ----------------------------------------------------------------
  // held until off interval ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lockout_out <= 1'b0;
    end else if (state_r == ST_ON && code_err_in) begin
      lockout_out <= 1'b1;
    end else if (off_end) begin
      lockout_out <= 1'b0;
    end
  end

  assign window_out = (state_r == ST_ON);

  park_no_window_a: assert property (state_r == ST_PARK |-> !window_out)
    else $error("window open while parked");

  off_to_on_a: assert property (
    off_end && sel_in != wake_rx_pkg::SEL_PARKED |=>
      window_out && !lockout_out)
    else $error("window did not start at off end");

  lock_window_a: assert property (
    (window_out && code_err_in) |=> lockout_out && !window_out)
    else $error("code error did not lock out");

endmodule // off_interval_timer

// >>> src/wake_rx_control.sv
// wake-up receiver control/status with AXI4-Lite register access.
// assumes the decoder drives its event pulses on this clock and that
// the detector output and slow oscillator arrive asynchronously.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps

// Operation
// - select all ones keeps detector off
// - count two^dbl times two^sel plus one
// - off interval ends at window start
// - status bit 7 tracks sampled detector
// - status bit zero when detector unpowered
// - interrupt only while enable bit set
// - code error locks out for interval
// - detector powered only when enable set
// - bit 2 selects 8 or 16 code
// - bit 1 selects detector sensitivity
// - bit 0 picks agc or data byte
// - status one layout, all reset zero
// - data ack clears ready and matches
// - carrier ack clears carrier flag
// - two-bit mode selects operating mode
// - off interval then window, repeating
module wake_rx_control #(
  parameter int SAMPLE_ON_CYC = wake_rx_pkg::SAMPLE_ON_CYC
) (
  input wire logic MCLK_IN, // system clock
  input wire logic RESET_IN, // synchronous reset, active high
  input wire logic [7:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [7:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic DET_OUT_IN, // detector output pin, async
  input wire logic SLOW_OSC_IN, // 1 ms slow oscillator, async
  input wire logic CODE_ERR_IN, // code error pulse from decoder
  input wire logic DATA_VALID_IN, // datagram accepted pulse
  input wire logic [7:0] DATA_BYTE_IN, // received data byte
  input wire logic CODE_A_IN, // code A match pulse
  input wire logic CODE_B_IN, // code B match pulse
  input wire logic CARRIER_IN, // carrier detected pulse
  input wire logic FILTER_IN, // filter in range level
  input wire logic CODE_VIOL_IN, // code violation level
  input wire logic [5:0] AGC_IN, // gain control setting
  output logic DET_POWER_OUT, // detector power enable
  output logic DECODER_EN_OUT, // decoder enable
  output logic DET_SAMPLE_OUT, // sampled detector to decoder
  output logic SHORT_CODE_OUT, // 8 bit wake code select
  output logic SENSITIVITY_OUT, // less sensitive threshold
  output logic [1:0] MODE_OUT, // operating mode field
  output logic IRQ_OUT // receiver interrupt, level
);
  default clocking chk_cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic det_meta_r, det_sync_r, slow_meta_r, slow_sync_r;
  logic slow_prev_r, slow_rise;

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      det_meta_r <= 1'b0;
      det_sync_r <= 1'b0;
      slow_meta_r <= 1'b0;
      slow_sync_r <= 1'b0;
      slow_prev_r <= 1'b0;
    end else begin
      det_meta_r <= DET_OUT_IN;
      det_sync_r <= det_meta_r;
      slow_meta_r <= SLOW_OSC_IN;
      slow_sync_r <= slow_meta_r;
      slow_prev_r <= slow_sync_r;
    end
  end

  assign slow_rise = slow_sync_r && !slow_prev_r;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic irq_en_r, dbl_r, det_en_r, short_code_r, sens_r, readback_r;
  logic [3:0] sel_r;
  logic [1:0] mode_r;
  logic ignore_r, data_ready_r, carrier_r, code_a_r, code_b_r;
  logic filter_r, viol_r, det_status_r;
  logic [7:0] rx_byte_r;
  logic [wake_rx_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_events;
  logic window, lockout;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held_r, w_held_r, wstrb0_r, wr_go, wr_lane;
  logic [7:0] awaddr_r, wdata_r, wr_addr, wr_data, rd_val;
  logic rd_go, rd_irq_clr, rd_hit, ack_data, ack_carrier;

  assign S_AXI_AWREADY = !aw_held_r && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held_r && !S_AXI_BVALID;
  assign wr_addr = aw_held_r ? awaddr_r : S_AXI_AWADDR;
  assign wr_data = w_held_r ? wdata_r : S_AXI_WDATA[7:0];
  assign wr_lane = w_held_r ? wstrb0_r : S_AXI_WSTRB[0];
  assign wr_go = (aw_held_r || (S_AXI_AWVALID && S_AXI_AWREADY)) &&
                 (w_held_r || (S_AXI_WVALID && S_AXI_WREADY));

  // address and data taken in either order, response after both
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= wake_rx_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_addr <= wake_rx_pkg::ADDR_IRQ_MASK &&
                        wr_addr[1:0] == 2'h0) ?
                       wake_rx_pkg::RESP_OKAY : wake_rx_pkg::RESP_DECERR;
      end else begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
          aw_held_r <= 1'b1;
          awaddr_r <= S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
          w_held_r <= 1'b1;
          wdata_r <= S_AXI_WDATA[7:0];
          wstrb0_r <= S_AXI_WSTRB[0];
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
          S_AXI_BVALID <= 1'b0;
        end
      end
    end
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_irq_clr = rd_go && S_AXI_ARADDR == wake_rx_pkg::ADDR_IRQ_STATUS;

  always_comb begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      wake_rx_pkg::ADDR_CTL_STAT_ZERO: rd_val = {det_status_r, irq_en_r,
        lockout, dbl_r, det_en_r, short_code_r, sens_r, readback_r};
      wake_rx_pkg::ADDR_CTL_STAT_ONE: rd_val = {data_ready_r, filter_r,
        carrier_r, 1'b0, code_b_r, code_a_r, viol_r, ignore_r};
      wake_rx_pkg::ADDR_RECEIVED_BYTE: rd_val = readback_r ? rx_byte_r :
        {2'b00, AGC_IN};
      wake_rx_pkg::ADDR_TIMING_CTL: rd_val = {2'b00, mode_r, sel_r};
      wake_rx_pkg::ADDR_IRQ_STATUS: rd_val = 8'(irq_stat_r);
      wake_rx_pkg::ADDR_IRQ_MASK: rd_val = 8'(irq_mask_r);
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= wake_rx_pkg::RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, rd_val};
      S_AXI_RRESP <= rd_hit ? wake_rx_pkg::RESP_OKAY :
                     wake_rx_pkg::RESP_DECERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      {irq_en_r, dbl_r, det_en_r} <= 3'b000;
      {short_code_r, sens_r, readback_r} <= 3'b000;
      ignore_r <= 1'b0;
      sel_r <= wake_rx_pkg::SEL_RESET;
      mode_r <= wake_rx_pkg::MODE_RESET;
      irq_mask_r <= '0;
    end else if (wr_go && wr_lane) begin
      case (wr_addr)
        wake_rx_pkg::ADDR_CTL_STAT_ZERO: begin
          irq_en_r <= wr_data[wake_rx_pkg::CS0_IRQ_EN];
          dbl_r <= wr_data[wake_rx_pkg::CS0_DOUBLE];
          det_en_r <= wr_data[wake_rx_pkg::CS0_DET_EN];
          short_code_r <= wr_data[wake_rx_pkg::CS0_SHORT_CODE];
          sens_r <= wr_data[wake_rx_pkg::CS0_SENS];
          readback_r <= wr_data[wake_rx_pkg::CS0_READBACK];
        end
        wake_rx_pkg::ADDR_CTL_STAT_ONE:
          ignore_r <= wr_data[wake_rx_pkg::CS1_IGNORE];
        wake_rx_pkg::ADDR_TIMING_CTL: begin
          sel_r <= wr_data[wake_rx_pkg::TC_SEL_LSB +: 4];
          mode_r <= wr_data[wake_rx_pkg::TC_MODE_LSB +: 2];
        end
        wake_rx_pkg::ADDR_IRQ_MASK:
          irq_mask_r <= wr_data[wake_rx_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign ack_data = wr_go && wr_lane &&
    wr_addr == wake_rx_pkg::ADDR_CTL_STAT_ONE &&
    wr_data[wake_rx_pkg::CS1_ACK_DATA];
  assign ack_carrier = wr_go && wr_lane &&
    wr_addr == wake_rx_pkg::ADDR_CTL_STAT_ONE &&
    wr_data[wake_rx_pkg::CS1_ACK_CARRIER];

  // ----------------------------------------------------------------
  // receiver flags; a set in the ack cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      {data_ready_r, code_a_r, code_b_r, carrier_r} <= 4'h0;
      {filter_r, viol_r} <= 2'b00;
      rx_byte_r <= 8'h00;
    end else begin
      data_ready_r <= DATA_VALID_IN || (data_ready_r && !ack_data);
      code_a_r <= CODE_A_IN || (code_a_r && !ack_data);
      code_b_r <= CODE_B_IN || (code_b_r && !ack_data);
      carrier_r <= CARRIER_IN || (carrier_r && !ack_carrier);
      filter_r <= FILTER_IN;
      viol_r <= CODE_VIOL_IN && det_en_r;
      if (DATA_VALID_IN) begin
        rx_byte_r <= DATA_BYTE_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencing and detector
  // ----------------------------------------------------------------
  // interval from select and doubling
  off_interval_timer #(
    .ON_CYC(SAMPLE_ON_CYC)
  ) u_timer (
    .clk_in(MCLK_IN),
    .rst_in(RESET_IN),
    .sel_in(sel_r),
    .dbl_in(dbl_r),
    .slow_rise_in(slow_rise),
    .code_err_in(CODE_ERR_IN),
    .window_out(window),
    .lockout_out(lockout)
  );

  assign DET_POWER_OUT = window && det_en_r && !lockout;
  assign DECODER_EN_OUT = DET_POWER_OUT;
  // ignore holds the sampled output low during the window
  assign DET_SAMPLE_OUT = det_status_r && !ignore_r;

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      det_status_r <= 1'b0;
    end else begin
      det_status_r <= DET_POWER_OUT && det_sync_r;
    end
  end

  assign SHORT_CODE_OUT = short_code_r;
  assign SENSITIVITY_OUT = sens_r;
  assign MODE_OUT = mode_r;

  // ----------------------------------------------------------------
  // interrupt; reading the status clears it
  // ----------------------------------------------------------------
  assign irq_events = {CODE_ERR_IN, CODE_B_IN, CODE_A_IN, CARRIER_IN,
                       DATA_VALID_IN};

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_events | (rd_irq_clr ? '0 : irq_stat_r);
    end
  end

  assign IRQ_OUT = irq_en_r && |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_gate_a: assert property (!irq_en_r |-> !IRQ_OUT)
    else $error("interrupt raised while disabled");
  det_zero_a: assert property (!$past(DET_POWER_OUT) |-> !det_status_r)
    else $error("detector status set while unpowered");
  det_track_a: assert property (
    $past(DET_POWER_OUT) |-> det_status_r == $past(det_sync_r))
    else $error("detector status does not track");
  det_enable_a: assert property (DET_POWER_OUT |-> det_en_r && window)
    else $error("detector powered without enable");
  data_ack_a: assert property (
    ack_data && !DATA_VALID_IN && !CODE_A_IN |=> !data_ready_r && !code_a_r)
    else $error("data ack did not clear flags");
  carrier_set_a: assert property (CARRIER_IN |=> carrier_r)
    else $error("carrier flag lost");

endmodule // wake_rx_control

// >>> verif/det_front_model.sv
// far-side model: free-running slow oscillator and detector pin.
// assumes the control block powers the detector through pwr_in.
`timescale 1ns/100ps
module det_front_model #(
  parameter int HALF = 10
) (
  input wire logic clk_in, // system clock
  input wire logic pwr_in, // detector power
  output logic slow_out, // slow oscillator
  output logic det_out // detector pin
);
  int n = 0;
  logic junk = 1'b0;
  initial slow_out = 1'b0;
  always @(posedge clk_in) begin
    junk <= ~junk;
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1) begin
      slow_out <= ~slow_out;
    end
  end
  // unpowered pin holds no level, so it toggles
  assign det_out = pwr_in ? 1'b1 : junk;
endmodule // det_front_model

// >>> verif/wake_rx_control_bench.sv
// self-checking bench for the wake-up receiver control block.
// assumes the far-side model drives the slow clock and detector pin.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module wake_rx_control_bench;
  localparam int ON = 20;
  localparam int T = 20;
  int errors = 0, n_compared = 0;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, byte_in = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cerr = 1'b0, dv = 1'b0;
  logic ca = 1'b0, cb = 1'b0, car = 1'b0, filt = 1'b0;
  logic [5:0] agc = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, slow, det, pwr, irq;
  logic short_o, sens_o, dec_en, samp;
  logic [1:0] bresp, rresp, mode_o, wrsp;
  always #4 clk = ~clk;
  det_front_model #(.HALF(T / 2)) det_front_model_i (.clk_in(clk),
    .pwr_in(pwr), .slow_out(slow), .det_out(det));
  wake_rx_control #(.SAMPLE_ON_CYC(ON)) wake_rx_control_i (
    .MCLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .DET_OUT_IN(det), .SLOW_OSC_IN(slow),
    .CODE_ERR_IN(cerr), .DATA_VALID_IN(dv), .DATA_BYTE_IN(byte_in),
    .CODE_A_IN(ca), .CODE_B_IN(cb), .CARRIER_IN(car), .FILTER_IN(filt),
    .CODE_VIOL_IN(1'b0), .AGC_IN(agc), .DET_POWER_OUT(pwr),
    .DECODER_EN_OUT(dec_en), .DET_SAMPLE_OUT(samp),
    .SHORT_CODE_OUT(short_o),
    .SENSITIVITY_OUT(sens_o), .MODE_OUT(mode_o), .IRQ_OUT(irq));
  // ----------------------------------------------------------------
  // bus and wait helpers
  // ----------------------------------------------------------------
  // readies are looked at on the falling edge, where they are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      wrsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    logic tr, tv;
    tv = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tv) begin
      @(negedge clk);
      tr = arvalid & arready;
      tv = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge clk);
      if (tr) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic wait_pwr(input logic lvl, output int k);
    k = 0;
    while (pwr !== lvl && k < 3000) begin
      @(negedge clk);
      k++;
    end
    `CHK("power wait", 1'b1, k < 3000)
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    logic [1:0] r;
    rd(8'h04, d, r);
    `CHK("cs1 reset", 8'h00, d)
    `CHK("short code reset", 1'b0, short_o)
    rd(8'h18, d, r);
    `CHK("unmapped resp", 2'h3, r)
    wr(8'h18, 8'h00);
    `CHK("unmapped wresp", 2'h3, wrsp)
    wr(8'h00, 8'h06);
    `CHK("write resp", 2'h0, wrsp)
    @(negedge clk);
    `CHK("short code", 1'b1, short_o)
    `CHK("sensitivity", 1'b1, sens_o)
    for (int m = 3; m >= 0; m--) begin
      wr(8'h0C, 8'(m << 4));
      @(negedge clk);
      `CHK("mode", 2'(m), mode_o)
    end
    $display("test regs done");
  endtask
  task automatic t_timer;
    logic [7:0] d;
    logic [1:0] r;
    int hi, lo, k;
    hi = 0;
    repeat (200) begin
      @(negedge clk);
      hi += int'(pwr);
    end
    `CHK("power while disabled", 0, hi)
    rd(8'h00, d, r);
    `CHK("status unpowered", 1'b0, d[7])
    for (int i = 0; i < 3; i++) begin
      wr(8'h0C, 8'(i > 0));
      wr(8'h00, 8'(i == 2 ? 8'h18 : 8'h08));
      wait_pwr(1'b1, k);
      // let the detector level pass the synchroniser first
      repeat (4) @(negedge clk);
      rd(8'h00, d, r);
      `CHK("status sampled", 1'b1, d[7])
      @(negedge clk);
      `CHK("sample out", 1'b1, samp)
      `CHK("decoder on", 1'b1, dec_en)
      wait_pwr(1'b0, k);
      hi = 0;
      wait_pwr(1'b1, k);
      while (pwr === 1'b1 && hi < 3000) begin
        @(negedge clk);
        hi++;
      end
      wait_pwr(1'b1, lo);
      `CHK("window length", ON, hi)
      k = (1 << (i == 2 ? 2 : i)) + 1;
      `CHK("off span", 1'b1, lo >= (k - 1) * T && lo <= k * T + 6)
    end
    @(posedge clk);
    cerr <= 1'b1;
    @(posedge clk);
    cerr <= 1'b0;
    @(negedge clk);
    `CHK("power in lockout", 1'b0, pwr)
    `CHK("decoder in lockout", 1'b0, dec_en)
    rd(8'h00, d, r);
    `CHK("lockout set", 1'b1, d[5])
    wait_pwr(1'b1, k);
    rd(8'h00, d, r);
    `CHK("lockout over", 1'b0, d[5])
    // park mid interval, so a timer that kept counting would wake
    wait_pwr(1'b0, k);
    wr(8'h0C, 8'h0F);
    hi = 0;
    repeat (600) begin
      @(negedge clk);
      hi += int'(pwr);
    end
    `CHK("parked power", 0, hi)
    $display("test timer done");
  endtask
  task automatic t_flags;
    logic [7:0] d;
    logic [1:0] r;
    rd(8'h10, d, r);
    wr(8'h14, 8'h1F);
    @(posedge clk);
    {dv, ca, cb, car} <= 4'hF;
    byte_in <= 8'hA5;
    filt <= 1'b1;
    agc <= 6'h2A;
    @(posedge clk);
    {dv, ca, cb, car} <= 4'h0;
    @(negedge clk);
    `CHK("irq disabled", 1'b0, irq)
    wr(8'h00, 8'h41);
    @(negedge clk);
    `CHK("irq enabled", 1'b1, irq)
    wr(8'h04, 8'h00);
    rd(8'h04, d, r);
    `CHK("cs1 flags", 8'hEC, d)
    rd(8'h08, d, r);
    `CHK("data byte", 8'hA5, d)
    wr(8'h00, 8'h40);
    rd(8'h08, d, r);
    `CHK("gain readback", 8'h2A, d)
    wr(8'h04, 8'h40);
    rd(8'h04, d, r);
    `CHK("data ack", 8'h60, d)
    wr(8'h04, 8'h10);
    rd(8'h04, d, r);
    `CHK("carrier ack", 8'h40, d)
    rd(8'h10, d, r);
    `CHK("irq status", 8'h0F, d)
    @(negedge clk);
    `CHK("irq after clear", 1'b0, irq)
    $display("test flags done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_timer();
    t_flags();
    tally_and_finish();
  end
endmodule // wake_rx_control_bench
